// ---- verilog/supervisor_defs.svh ----
`ifndef SUPERVISOR_DEFS_SVH
`define SUPERVISOR_DEFS_SVH

// register map (byte addresses on the plain port)
`define ADDR_CONTROL 4'h0
`define ADDR_STATUS 4'h4
`define ADDR_VOLTAGE 4'h8
`define ADDR_REFERENCE 4'hC
`define ADDR_PERIOD 4'h0
// control fields
`define CTRL_ENABLE_BIT 0
`define CTRL_RESET_VALUE 8'h01
// status fields
`define ST_RUNNING_BIT 0
`define ST_SOFTSTART_BIT 1
`define ST_IN_WINDOW_BIT 2
`define ST_UV_BIT 3
`define ST_OV_BIT 4
`define ST_INHIBIT_BIT 5
// soft start length in clock periods
`define SOFTSTART_CYCLES 2048
// thresholds as fractions: window 12 percent, uv 60 percent
`define WINDOW_PCT 12
`define UV_PCT 60
`define PCT_FULL 100
// uv enable reference level in millivolts
`define UV_ENABLE_MV 600
// voltage code: 0.800 V plus 25 mV steps
`define CODE_BASE_MV 800
`define CODE_STEP_MV 25
// fixed overvoltage threshold in millivolts
`define OV_THRESHOLD_MV 1800
// switching period in core clock cycles (200 MHz / 200 kHz)
`define SWITCH_PERIOD 1000
// uv must persist longer than one switching clock period
`define UV_QUALIFY 1000

`endif

// ---- verilog/supervisor_pkg.sv ----
package supervisor_pkg;
	typedef enum {ST_OFF, ST_SOFTSTART, ST_RUN, ST_UV_LATCH, ST_OV_LATCH} state_t;
	typedef struct packed
	{
		logic high1;
		logic low1;
		logic high2;
		logic low2;
	} gates_t;
endpackage

// ---- verilog/phase_pwm.sv ----
`timescale 1ns/1ps
`default_nettype none
// one phase: high switch on for the first duty counts of each period
module phase_pwm #(
	parameter int PERIOD = 1000,
	parameter int OFFSET = 0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	input wire logic [9:0] duty,
	output logic high_on,
	output logic low_on
);
	initial
	begin
		if (PERIOD < 2 || PERIOD > 1024 || OFFSET >= PERIOD)
			$error("phase_pwm: bad period or offset");
	end
	logic [9:0] count;
	wire wrap = (count == 10'(PERIOD - 1));
	wire next_high = run && (count < duty);
	always_ff @(posedge clk)
	begin
		if (rst || !run)
			count <= 10'(OFFSET);
		else
			count <= wrap ? 10'h000 : count + 10'h001;
	end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			high_on <= 1'b0;
			low_on <= 1'b0;
		end
		else
		begin
			high_on <= next_high;
			low_on <= run && !next_high;
		end
	end
endmodule
`default_nettype wire

// ---- verilog/softstart_fault_sequencer.sv ----
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_defs.svh"
//
// Overview of operation
// - The in-window flag stays low while the sensed voltage is more than 12 percent from target.
// - The in-window flag is forced low during soft start and compared only after 2048 cycles.
// - Sensed voltage below 60 percent of reference for over one switching clock period turns all switches off and raises fault.
// - The undervoltage fault is latched until power is cycled.
// - Reaching the overvoltage level latches both low switches on, both high off, and raises fault.
// - Overvoltage checking runs in soft start; undervoltage only once the reference reaches 0.6 V.
// - In soft start undervoltage uses the ramping reference and overvoltage uses the fixed 1800 mV level.
// - The reference ramps from zero to the coded value over 2048 clock periods.
// - Both phases switch under closed-loop control as soon as soft start begins.
// - Soft start waits until both supplies are above their turn-on thresholds.
// - A supply undervoltage during operation shuts the device down.
// - A low inhibit pin disables all switches except the latched overvoltage low switches, and all protections, until released.
// - The two phases run 180 degrees apart.
module softstart_fault_sequencer #(
	parameter int RAMP_CYCLES = `SOFTSTART_CYCLES,
	parameter int UV_CYCLES = `UV_QUALIFY,
	parameter int PERIOD = `SWITCH_PERIOD
) (
	input wire logic CORE_CLK,
	input wire logic RESET,
	input wire logic [3:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	input wire logic [4:0] VOLTAGE_CODE_INPUTS,
	input wire logic [11:0] SENSED_OUTPUT_VOLTAGE,
	input wire logic CONTROL_SUPPLY_OK,
	input wire logic DRIVER_SUPPLY_OK,
	input wire logic INHIBIT_PIN_LOW,
	input wire logic [9:0] LOOP_DUTY,
	output logic [11:0] LOOP_REFERENCE,
	output logic OUTPUT_IN_WINDOW_FLAG_OE,
	output logic FAULT_INDICATOR_PIN,
	output supervisor_pkg::gates_t GATES
);
	initial
	begin
		if (RAMP_CYCLES < 2 || RAMP_CYCLES > 65535 || UV_CYCLES < 1 ||
			UV_CYCLES > 65535)
			$error("softstart_fault_sequencer: bad ramp or uv count");
	end

	// pin synchronisers
	logic [4:0] code_s1, code_s2;
	logic [11:0] sensed_output_voltage_s1, sensed_output_voltage_s2;
	logic [2:0] misc_s1, misc_s2;
	always_ff @(posedge CORE_CLK)
	begin
		code_s1 <= VOLTAGE_CODE_INPUTS;
		code_s2 <= code_s1;
		sensed_output_voltage_s1 <= SENSED_OUTPUT_VOLTAGE;
		sensed_output_voltage_s2 <= sensed_output_voltage_s1;
		misc_s1 <= {INHIBIT_PIN_LOW, DRIVER_SUPPLY_OK, CONTROL_SUPPLY_OK};
		misc_s2 <= misc_s1;
	end
	wire supplies_ok = misc_s2[0] && misc_s2[1];
	wire inhibit = misc_s2[2];

	// register port
	logic [7:0] control;
	wire enable = control[`CTRL_ENABLE_BIT];
	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
			control <= `CTRL_RESET_VALUE;
		else if (WR && ADDR == `ADDR_CONTROL)
			control <= WDATA;
	end

	// final reference in millivolts from the voltage code
	wire [11:0] final_ref = 12'(`CODE_BASE_MV) +
		12'(code_s2) * 12'(`CODE_STEP_MV);

	supervisor_pkg::state_t state, next_state;
	logic [15:0] ramp_count;
	logic [15:0] uv_count;
	logic [11:0] reference;
	wire ramp_done = (ramp_count == 16'(RAMP_CYCLES - 1));

	// ramp reference: final * count / (length - 1)
	wire [27:0] ramp_product = 28'(final_ref) * 28'(ramp_count);
	wire [11:0] ramp_ref = 12'(ramp_product / 28'(RAMP_CYCLES - 1));
	wire [11:0] next_reference = (state == supervisor_pkg::ST_SOFTSTART) ?
		ramp_ref : final_ref;

	// threshold compares scaled to avoid division
	wire [19:0] sensed_output_voltage_scaled = 20'(sensed_output_voltage_s2) * 20'(`PCT_FULL);
	wire [19:0] uv_limit = 20'(reference) * 20'(`UV_PCT);
	wire [19:0] win_low = 20'(final_ref) * 20'(`PCT_FULL - `WINDOW_PCT);
	wire [19:0] win_high = 20'(final_ref) * 20'(`PCT_FULL + `WINDOW_PCT);
	wire below_uv = sensed_output_voltage_scaled < uv_limit;
	wire in_window = (sensed_output_voltage_scaled >= win_low) && (sensed_output_voltage_scaled <= win_high);
	// overvoltage against the fixed level, independent of ramp
	wire over_ov = sensed_output_voltage_s2 >= 12'(`OV_THRESHOLD_MV);
	wire uv_armed = reference >= 12'(`UV_ENABLE_MV);
	wire active = (state == supervisor_pkg::ST_SOFTSTART) ||
		(state == supervisor_pkg::ST_RUN);
	// protections only while switching and not inhibited
	wire ov_check = active && !inhibit;
	wire uv_check = active && !inhibit && uv_armed && below_uv;
	wire uv_trip = uv_check && (uv_count == 16'(UV_CYCLES - 1));

	always_comb
	begin
		next_state = state;
		case (state)
			supervisor_pkg::ST_OFF:
				if (supplies_ok && !inhibit && enable)
					next_state = supervisor_pkg::ST_SOFTSTART;
			supervisor_pkg::ST_SOFTSTART, supervisor_pkg::ST_RUN:
				if (ov_check && over_ov)
					next_state = supervisor_pkg::ST_OV_LATCH;
				else if (uv_trip)
					next_state = supervisor_pkg::ST_UV_LATCH;
				else if (!supplies_ok || inhibit || !enable)
					next_state = supervisor_pkg::ST_OFF;
				else if (state == supervisor_pkg::ST_SOFTSTART && ramp_done)
					next_state = supervisor_pkg::ST_RUN;
			// latched until power cycle resets the core
			supervisor_pkg::ST_UV_LATCH:
				next_state = supervisor_pkg::ST_UV_LATCH;
			supervisor_pkg::ST_OV_LATCH:
				next_state = supervisor_pkg::ST_OV_LATCH;
			default:
				next_state = supervisor_pkg::ST_OFF;
		endcase
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
			state <= supervisor_pkg::ST_OFF;
		else
			state <= next_state;
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET || state != supervisor_pkg::ST_SOFTSTART)
			ramp_count <= 16'h0000;
		else if (!ramp_done)
			ramp_count <= ramp_count + 16'h0001;
	end

	// qualify count restarts when voltage recovers
	always_ff @(posedge CORE_CLK)
	begin
		if (RESET || !uv_check)
			uv_count <= 16'h0000;
		else if (!uv_trip)
			uv_count <= uv_count + 16'h0001;
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET || state == supervisor_pkg::ST_OFF)
			reference <= 12'h000;
		else
			reference <= next_reference;
	end
	assign LOOP_REFERENCE = reference;

	// open drain: enable pulls low unless in run and in window
	logic window_good;
	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
			window_good <= 1'b0;
		else
			window_good <= (next_state == supervisor_pkg::ST_RUN) &&
				in_window;
	end
	assign OUTPUT_IN_WINDOW_FLAG_OE = !window_good;

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
			FAULT_INDICATOR_PIN <= 1'b0;
		else
			FAULT_INDICATOR_PIN <=
				(next_state == supervisor_pkg::ST_UV_LATCH) ||
				(next_state == supervisor_pkg::ST_OV_LATCH);
	end

	// two phases 180 degrees apart
	wire run_pwm = active && !inhibit;
	logic hi1, lo1, hi2, lo2;
	phase_pwm #(.PERIOD(PERIOD), .OFFSET(0)) phase_a (
		.clk(CORE_CLK),
		.rst(RESET),
		.run(run_pwm),
		.duty(LOOP_DUTY),
		.high_on(hi1),
		.low_on(lo1)
	);
	phase_pwm #(.PERIOD(PERIOD), .OFFSET(PERIOD / 2)) phase_b (
		.clk(CORE_CLK),
		.rst(RESET),
		.run(run_pwm),
		.duty(LOOP_DUTY),
		.high_on(hi2),
		.low_on(lo2)
	);
	wire ov_latched = (state == supervisor_pkg::ST_OV_LATCH);
	always_comb
	begin
		// crowbar: lows on, highs off other stops all off
		GATES.high1 = hi1 && active && !inhibit;
		GATES.low1 = ov_latched || (lo1 && active && !inhibit);
		GATES.high2 = hi2 && active && !inhibit;
		GATES.low2 = ov_latched || (lo2 && active && !inhibit);
	end

	// read port
	wire [7:0] status = {2'b00, inhibit,
		state == supervisor_pkg::ST_OV_LATCH,
		state == supervisor_pkg::ST_UV_LATCH, window_good,
		state == supervisor_pkg::ST_SOFTSTART, active};
	wire [7:0] read_mux =
		(ADDR == `ADDR_CONTROL) ? control :
		(ADDR == `ADDR_STATUS) ? status :
		(ADDR == `ADDR_VOLTAGE) ? {3'b000, code_s2} :
		(ADDR == `ADDR_REFERENCE) ? reference[11:4] : 8'h00;
	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
			RDATA <= 8'h00;
		else if (RD)
			RDATA <= read_mux;
		else
			RDATA <= 8'h00;
	end
endmodule
`default_nettype wire

// ---- verif/sense_plant.sv ----
`timescale 1ns/1ps
`default_nettype none
// comparator front end: sensed level derived from the reference
module sense_plant (
	input wire logic [11:0] ref_mv,
	input wire logic [1:0] mode,
	output logic [11:0] sense_mv
);
	// 0 track, 1 sag to 70 percent, 2 collapse, 3 overshoot
	assign sense_mv = mode == 2'h0 ? ref_mv :
		mode == 2'h1 ? 12'(ref_mv * 32'h7 / 32'hA) :
		mode == 2'h2 ? 12'h000 : 12'h76C;
endmodule
`default_nettype wire

// ---- verif/seq_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module seq_checker #(
	parameter int UV_CYCLES = 4
) (
	input wire logic CORE_CLK,
	input wire logic RESET,
	input wire logic RD,
	input wire logic [7:0] RDATA,
	input wire logic [11:0] SENSED_OUTPUT_VOLTAGE,
	input wire logic CONTROL_SUPPLY_OK,
	input wire logic DRIVER_SUPPLY_OK,
	input wire logic INHIBIT_PIN_LOW,
	input wire logic [11:0] LOOP_REFERENCE,
	input wire logic OUTPUT_IN_WINDOW_FLAG_OE,
	input wire logic FAULT_INDICATOR_PIN,
	input wire supervisor_pkg::gates_t GATES
);
	wire logic ok = CONTROL_SUPPLY_OK && DRIVER_SUPPLY_OK && !INHIBIT_PIN_LOW;
	wire logic uv = ok && !FAULT_INDICATOR_PIN && LOOP_REFERENCE >= 12'h258
		&& SENSED_OUTPUT_VOLTAGE * 32'h64 < LOOP_REFERENCE * 32'h3C;
	int cnt;
	// length of the current undervoltage run
	always_ff @(posedge CORE_CLK)
		cnt <= (RESET || !uv) ? 0 : cnt + 1;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RESET);
	a_fault_sticky:
	assert property (FAULT_INDICATOR_PIN |=> FAULT_INDICATOR_PIN)
		else $error("fault indicator dropped");
	a_ov_gates:
	assert property (FAULT_INDICATOR_PIN && GATES.low1 |->
		!GATES.high1 && !GATES.high2 && GATES.low2) else $error("ov gates");
	a_uv_gates:
	assert property (FAULT_INDICATOR_PIN && !GATES.low1 |->
		!GATES.high1 && !GATES.high2 && !GATES.low2) else $error("uv gates");
	a_ov_trip:
	assert property ((ok && LOOP_REFERENCE != 12'h000 &&
		SENSED_OUTPUT_VOLTAGE >= 12'h708)[*4] |-> ##[0:3] FAULT_INDICATOR_PIN)
		else $error("ov not tripped");
	a_uv_trip:
	assert property (cnt == UV_CYCLES + 6 |-> FAULT_INDICATOR_PIN)
		else $error("uv not tripped");
	a_ramp_flag_low:
	assert property (LOOP_REFERENCE > $past(LOOP_REFERENCE) |->
		OUTPUT_IN_WINDOW_FLAG_OE) else $error("flag released in ramp");
	a_read_idle:
	assert property (!$past(RD) |-> RDATA == 8'h00) else $error("rdata idle");
	a_off_gates:
	assert property ((!ok && !FAULT_INDICATOR_PIN)[*5] |-> !GATES.high1 &&
		!GATES.low1 && !GATES.high2 && !GATES.low2 && LOOP_REFERENCE == 12'h000)
		else $error("switching while off");
endmodule
bind softstart_fault_sequencer seq_checker #(.UV_CYCLES(UV_CYCLES)) chk_u (
	.CORE_CLK(CORE_CLK), .RESET(RESET), .RD(RD), .RDATA(RDATA),
	.SENSED_OUTPUT_VOLTAGE(SENSED_OUTPUT_VOLTAGE),
	.CONTROL_SUPPLY_OK(CONTROL_SUPPLY_OK), .DRIVER_SUPPLY_OK(DRIVER_SUPPLY_OK),
	.INHIBIT_PIN_LOW(INHIBIT_PIN_LOW), .LOOP_REFERENCE(LOOP_REFERENCE),
	.OUTPUT_IN_WINDOW_FLAG_OE(OUTPUT_IN_WINDOW_FLAG_OE),
	.FAULT_INDICATOR_PIN(FAULT_INDICATOR_PIN), .GATES(GATES));
`default_nettype wire

// ---- verif/softstart_fault_sequencer_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module softstart_fault_sequencer_tb;
	localparam int RAMP = 16;
	logic clk = 0, rst = 1, wr = 0, rd = 0, pend = 0, csup = 0, dsup = 0, inh = 0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00, rdata, m;
	logic [4:0] code = 5'h00;
	logic [9:0] duty = 10'h000;
	logic [1:0] mode = 2'h0;
	logic [11:0] sense, ref_mv, f;
	logic oe, flt;
	supervisor_pkg::gates_t g;
	logic [7:0] qe[$], qm[$];
	int err_total = 0, compares = 0, seed = 32'hEDA6, a, b, c;
	always #2.5 clk = ~clk;
	softstart_fault_sequencer #(.RAMP_CYCLES(RAMP), .UV_CYCLES(4), .PERIOD(20))
	dut_u (.CORE_CLK(clk), .RESET(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
		.RD(rd), .RDATA(rdata), .VOLTAGE_CODE_INPUTS(code),
		.SENSED_OUTPUT_VOLTAGE(sense), .CONTROL_SUPPLY_OK(csup),
		.DRIVER_SUPPLY_OK(dsup), .INHIBIT_PIN_LOW(inh), .LOOP_DUTY(duty),
		.LOOP_REFERENCE(ref_mv), .OUTPUT_IN_WINDOW_FLAG_OE(oe),
		.FAULT_INDICATOR_PIN(flt), .GATES(g));
	sense_plant plant_u (.ref_mv(ref_mv), .mode(mode), .sense_mv(sense));
	task chk(input string n, input logic [11:0] e, s);
		compares++;
		if (s !== e)
		begin
			err_total++;
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
		end
	endtask
	task test_done;
		$display("errors %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task rd_reg(input logic [3:0] ad, input logic [7:0] e, mk);
		@(posedge clk);
		addr <= ad;
		rd <= 1;
		qe.push_back(e);
		qm.push_back(mk);
		@(posedge clk);
		rd <= 0;
	endtask
	task wr_reg(input logic [3:0] ad, input logic [7:0] d);
		@(posedge clk);
		addr <= ad;
		wdata <= d;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
	endtask
	// read data stand only in the cycle after the strobe
	always @(negedge clk)
	begin
		if (pend)
		begin
			m = qm.pop_front();
			chk("rdata", 12'(qe.pop_front() & m), 12'(rdata & m));
		end
		pend = rd;
	end
	task up;
		int n;
		n = 0;
		@(posedge clk);
		csup <= 1;
		dsup <= 1;
		while (ref_mv === 12'h000 && n < 40)
		begin
			@(negedge clk);
			n++;
		end
		n = 0;
		while (ref_mv !== f && n < 40)
		begin
			@(negedge clk);
			n++;
		end
		chk("ramp", 12'h1, 12'(n >= RAMP - 2 && n <= RAMP + 1));
		cyc(6);
		chk("window", 12'h0, 12'(oe));
	endtask
	initial
	begin
		repeat (30000) @(posedge clk);
		err_total++;
		test_done;
	end
	initial
	begin
		@(posedge clk);
		code <= 5'($random(seed));
		duty <= 10'(1 + {$random(seed)} % 9);
		cyc(15);
		rst <= 0;
		f = 12'h320 + 12'h019 * 12'(code);
		rd_reg(4'h0, 8'h01, 8'hFF);
		rd_reg(4'h4, 8'h00, 8'hFF);
		rd_reg(4'h2, 8'h00, 8'hFF);
		rd_reg(4'h8, 8'(code), 8'hFF);
		up;
		rd_reg(4'hC, f[11:4], 8'hFF);
		rd_reg(4'h4, 8'h05, 8'hFF);
		a = 0;
		b = 0;
		c = 0;
		repeat (40)
		begin
			@(negedge clk);
			a += g.high1;
			b += g.high2;
			c += g.high1 & g.high2;
		end
		chk("high1", 12'(2 * duty), 12'(a));
		chk("high2", 12'(2 * duty), 12'(b));
		chk("overlap", 12'h0, 12'(c));
		cyc(1);
		mode <= 2'h1;
		cyc(8);
		chk("window", 12'h1, 12'(oe));
		mode <= 2'h0;
		inh <= 1;
		cyc(8);
		chk("gates", 12'h0, 12'(g));
		rd_reg(4'h4, 8'h20, 8'h21);
		inh <= 0;
		up;
		repeat (6)
		begin
			mode <= 2'h2;
			cyc(2);
			mode <= 2'h0;
			cyc(3);
		end
		chk("fault", 12'h0, 12'(flt));
		mode <= 2'h2;
		cyc(12);
		chk("fault", 12'h1, 12'(flt));
		chk("gates", 12'h0, 12'(g));
		mode <= 2'h0;
		cyc(12);
		rd_reg(4'h4, 8'h08, 8'h18);
		chk("fault", 12'h1, 12'(flt));
		rst <= 1;
		mode <= 2'h3;
		cyc(4);
		rst <= 0;
		cyc(12);
		chk("fault", 12'h1, 12'(flt));
		chk("gates", 12'h5, 12'(g));
		rd_reg(4'h4, 8'h10, 8'h18);
		rst <= 1;
		mode <= 2'h0;
		cyc(4);
		rst <= 0;
		up;
		dsup <= 0;
		cyc(6);
		chk("gates", 12'h0, 12'(g));
		cyc(30);
		chk("ref", 12'h0, ref_mv);
		wr_reg(4'h0, 8'h00);
		dsup <= 1;
		cyc(30);
		chk("ref", 12'h0, ref_mv);
		wr_reg(4'h0, 8'h01);
		up;
		test_done;
	end
endmodule
`default_nettype wire
